//--- rss_pkg.sv
package rss_pkg;

	// Register map
	localparam int unsigned ADDR_W               = 6;
	localparam logic [5:0]  RESET_CAUSE_OFFSET   = 6'h34;
	localparam int unsigned PIN_FLAG_BIT         = 1;
	localparam int unsigned POWER_FLAG_BIT       = 0;
	localparam logic [7:0]  RESERVED_MASK        = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ        = 8'h00;

	// Flag values after a power-up reset (pin flag undefined, held at zero)
	localparam logic        PIN_FLAG_POR_VALUE   = 1'b0;
	localparam logic        POWER_FLAG_POR_VALUE = 1'b1;

	// Start-up time fuse settings (a zero bit is a programmed fuse)
	localparam logic [1:0]  FUSE_CLK_5           = 2'b00;
	localparam logic [1:0]  FUSE_OSC_512         = 2'b01;
	localparam logic [1:0]  FUSE_OSC_4K          = 2'b10;
	localparam logic [1:0]  FUSE_OSC_16K         = 2'b11;

	// Delay lengths in counted events
	localparam int unsigned DLY_W                = 15;
	localparam int unsigned CLOCK_CYCLES_00      = 5;
	localparam int unsigned OSC_CYCLES_01        = 512;
	localparam int unsigned OSC_CYCLES_10        = 4096;
	localparam int unsigned OSC_CYCLES_11        = 16384;

	// Watchdog reset pulse: one core clock cycle
	localparam int unsigned WDT_PULSE_CYCLES     = 1;

	// Execution restart address
	localparam logic [15:0] START_ADDRESS        = 16'h0000;

	// Sequencer states
	typedef enum logic [1:0]
	{
		ST_HOLD,
		ST_COUNT,
		ST_RUN,
		ST_WAKE
	} rss_state_t;

endpackage : rss_pkg

//--- rss_dly_if.sv
`timescale 1ns/1ps

// Link between the sequencer and its delay counter
interface rss_dly_if;
	logic       clear;
	logic [1:0] sel;
	logic       osc_tick;
	logic       expired;

	modport ctl
	(
		output clear,
		output sel,
		output osc_tick,
		input  expired
	);

	modport cnt
	(
		input  clear,
		input  sel,
		input  osc_tick,
		output expired
	);
endinterface : rss_dly_if

//--- rss_delay_counter.sv
`timescale 1ns/1ps

module rss_delay_counter
#(
	parameter int unsigned CYC_00 = rss_pkg::CLOCK_CYCLES_00,
	parameter int unsigned CYC_01 = rss_pkg::OSC_CYCLES_01,
	parameter int unsigned CYC_10 = rss_pkg::OSC_CYCLES_10,
	parameter int unsigned CYC_11 = rss_pkg::OSC_CYCLES_11
)
(
	input  wire logic clock_i,
	input  wire logic arst_i,
	rss_dly_if.cnt    dly
);
	import rss_pkg::*;

	logic [DLY_W-1:0] count_r;
	logic             expired_r;
	logic             qual;
	logic [DLY_W-1:0] last;

	// Last count value for a fuse setting
	function automatic logic [DLY_W-1:0] last_count(input logic [1:0] sel);
		case (sel)
			FUSE_CLK_5:   last_count = DLY_W'(CYC_00 - 1);
			FUSE_OSC_512: last_count = DLY_W'(CYC_01 - 1);
			FUSE_OSC_4K:  last_count = DLY_W'(CYC_10 - 1);
			default:      last_count = DLY_W'(CYC_11 - 1);
		endcase
	endfunction

	// Setting 00 counts core clocks, never the watchdog oscillator
	assign qual = (dly.sel == FUSE_CLK_5) ? 1'b1 : dly.osc_tick;
	assign last = last_count(dly.sel);

	// Event counter, restarted by any reset source
	always_ff @(posedge clock_i or posedge arst_i)
	begin
		if (arst_i)
			count_r <= '0;
		else if (dly.clear)
			count_r <= '0;
		else if (qual && !expired_r && count_r != last)
			count_r <= count_r + DLY_W'(1);
	end

	// Expiry flag, held until the next clear
	always_ff @(posedge clock_i or posedge arst_i)
	begin
		if (arst_i)
			expired_r <= 1'b0;
		else if (dly.clear)
			expired_r <= 1'b0;
		else if (qual && count_r == last)
			expired_r <= 1'b1;
	end

	assign dly.expired = expired_r;

endmodule // rss_delay_counter

//--- rss_sequencer.sv
`timescale 1ns/1ps

module rss_sequencer
(
	input  wire logic                      clock_i,
	input  wire logic                      reset_i,
	input  wire logic                      ext_reset_n_i,
	input  wire logic                      wdt_timeout_i,
	input  wire logic                      wdt_enable_i,
	input  wire logic                      wdt_osc_tick_i,
	input  wire logic [1:0]                start_up_time_fuses_i,
	input  wire logic                      sleep_wake_i,
	input  wire logic [rss_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [7:0]                wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic      [7:0]                rdata_o,
	output logic                           core_reset_o,
	output logic                           io_reset_o,
	output logic                           core_stall_o,
	output logic                           wdt_reset_pulse_o,
	output logic      [15:0]               start_address_o
);
	import rss_pkg::*;

	rss_dly_if  dly ();

	logic       arst;
	logic       wdt_pulse_r;
	logic       wdt_fire;
	rss_state_t state_r;
	rss_state_t state_nxt;
	logic       pin_flag_r;
	logic       power_flag_r;
	logic       sel_reg;
	logic       core_reset_nxt;
	logic       core_stall_nxt;

	// Power-up or low pin: held asynchronously, clock or not
	assign arst = reset_i | ~ext_reset_n_i;

	// Watchdog fires only when enabled
	assign wdt_fire = wdt_timeout_i & wdt_enable_i & ~wdt_pulse_r;

	// One-cycle internal watchdog reset pulse
	always_ff @(posedge clock_i or posedge arst)
	begin
		if (arst)
			wdt_pulse_r <= 1'b0;
		else
			wdt_pulse_r <= wdt_fire;
	end

	assign wdt_reset_pulse_o = wdt_pulse_r;

	// Counter kept clear while a source is active
	assign dly.clear    = (state_r == ST_HOLD) || wdt_fire || wdt_pulse_r
		|| (state_r == ST_RUN && !sleep_wake_i);
	assign dly.sel      = start_up_time_fuses_i;
	assign dly.osc_tick = wdt_osc_tick_i;

	rss_delay_counter u_delay
	(
		.clock_i (clock_i),
		.arst_i  (arst),
		.dly     (dly)
	);

	// Sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_HOLD:
				state_nxt = ST_COUNT;
			ST_COUNT:
			begin
				if (wdt_fire || wdt_pulse_r)
					state_nxt = ST_COUNT;
				else if (dly.expired)
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				if (wdt_fire)
					state_nxt = ST_COUNT;
				else if (sleep_wake_i)
					state_nxt = ST_WAKE;
			end
			ST_WAKE:
			begin
				if (wdt_fire)
					state_nxt = ST_COUNT;
				else if (dly.expired)
					state_nxt = ST_RUN;
			end
			default:
				state_nxt = ST_HOLD;
		endcase
	end

	// State register, forced to hold by any asynchronous source
	always_ff @(posedge clock_i or posedge arst)
	begin
		if (arst)
			state_r <= ST_HOLD;
		else
			state_r <= state_nxt;
	end

	// Core held in reset until the delay has run out
	assign core_reset_nxt = (state_nxt == ST_HOLD) || (state_nxt == ST_COUNT) || wdt_fire;
	assign core_stall_nxt = (state_nxt == ST_WAKE);

	always_ff @(posedge clock_i or posedge arst)
	begin
		if (arst)
			core_reset_o <= 1'b1;
		else
			core_reset_o <= core_reset_nxt;
	end

	// I/O registers reset alongside the core
	always_ff @(posedge clock_i or posedge arst)
	begin
		if (arst)
			io_reset_o <= 1'b1;
		else
			io_reset_o <= core_reset_nxt;
	end

	// Wake-up stall, no reset of state
	always_ff @(posedge clock_i or posedge arst)
	begin
		if (arst)
			core_stall_o <= 1'b0;
		else
			core_stall_o <= core_stall_nxt;
	end

	// Restart address
	always_ff @(posedge clock_i or posedge arst)
	begin
		if (arst)
			start_address_o <= START_ADDRESS;
		else
			start_address_o <= START_ADDRESS;
	end

	assign sel_reg = (addr_i == RESET_CAUSE_OFFSET);

	// Pin flag: set by pin reset, cleared by power-up, kept by watchdog
	always_ff @(posedge clock_i or posedge reset_i or negedge ext_reset_n_i)
	begin
		if (reset_i)
			pin_flag_r <= PIN_FLAG_POR_VALUE;
		else if (!ext_reset_n_i)
			pin_flag_r <= 1'b1;
		else if (wr_i && sel_reg)
			pin_flag_r <= wdata_i[PIN_FLAG_BIT];
	end

	// Power flag: set by power-up or a register write, kept by other resets
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			power_flag_r <= POWER_FLAG_POR_VALUE;
		else if (wr_i && sel_reg)
			power_flag_r <= wdata_i[POWER_FLAG_BIT];
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			rdata_o <= 8'h00;
		else if (rd_i && sel_reg)
			rdata_o <= RESERVED_MASK | {6'h00, pin_flag_r, power_flag_r};
		else
			rdata_o <= UNMAPPED_READ;
	end

endmodule // rss_sequencer

//--- rss_osc_model.sv
`timescale 1ns/1ps

// Watchdog oscillator: one tick every DIV core clocks, free running
module rss_osc_model
#(
	parameter int DIV = 2
)
(
	input  wire logic clock_i,
	output logic      tick_o = 1'b0
);
	int cnt_r = 0;

	// Divider; each tick stands for one oscillator cycle of DIV core clocks
	always_ff @(posedge clock_i)
	begin
		cnt_r  <= (cnt_r == DIV - 1) ? 0 : cnt_r + 1;
		tick_o <= (cnt_r == DIV - 1);
	end
endmodule // rss_osc_model

//--- rss_sequencer_chk.sv
`timescale 1ns/1ps

module rss_sequencer_chk
(
	input wire logic       clock_i,
	input wire logic       reset_i,
	input wire logic       ext_reset_n_i,
	input wire logic       wdt_timeout_i,
	input wire logic       wdt_enable_i,
	input wire logic [1:0] start_up_time_fuses_i,
	input wire logic       sleep_wake_i,
	input wire logic [7:0] rdata_o,
	input wire logic       core_reset_o,
	input wire logic       io_reset_o,
	input wire logic       core_stall_o,
	input wire logic       wdt_reset_pulse_o,
	input wire logic [15:0] start_address_o
);
	import rss_pkg::*;

	// One domain, power-up reset masks everything
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);

	a_rsvd_read_zero: assert property (rdata_o[7:2] == 6'h00) else $error("reserved bits set");
	a_wdt_fire_pulse: assert property ($rose(wdt_timeout_i) && wdt_enable_i && !core_reset_o
		|=> wdt_reset_pulse_o && core_reset_o) else $error("no watchdog reset");
	a_wdt_pulse_one: assert property ($rose(wdt_reset_pulse_o) |=> !wdt_reset_pulse_o) else $error("pulse long");
	a_wdt_when_off: assert property (wdt_timeout_i && !wdt_enable_i && !core_reset_o
		|=> !wdt_reset_pulse_o && !core_reset_o) else $error("watchdog reset while off");
	a_wdt_fast_delay: assert property (disable iff (reset_i || !ext_reset_n_i)
		$fell(wdt_reset_pulse_o) && start_up_time_fuses_i == 2'h0 |-> core_reset_o[*5] ##[1:2] !core_reset_o)
		else $error("watchdog delay wrong");
	a_pin_async_hold: assert property (!ext_reset_n_i |-> core_reset_o && !core_stall_o)
		else $error("pin low not holding");
	a_pin_fast_delay: assert property (disable iff (reset_i || !ext_reset_n_i)
		$rose(ext_reset_n_i) && start_up_time_fuses_i == 2'h0 |-> core_reset_o[*7] ##1 !core_reset_o)
		else $error("pin delay wrong");
	a_io_start_addr: assert property (io_reset_o == core_reset_o && start_address_o == 16'h0000)
		else $error("io reset or start address wrong");
	a_wake_stall: assert property (sleep_wake_i && !core_reset_o && !core_stall_o |=> core_stall_o)
		else $error("no wake stall");
endmodule // rss_sequencer_chk

bind rss_sequencer rss_sequencer_chk u_chk (.clock_i, .reset_i, .ext_reset_n_i, .wdt_timeout_i, .wdt_enable_i,
	.start_up_time_fuses_i, .sleep_wake_i, .rdata_o, .core_reset_o, .io_reset_o, .core_stall_o,
	.wdt_reset_pulse_o, .start_address_o);

//--- tb.sv
`timescale 1ns/1ps

module tb;
	import rss_pkg::*;
	logic        clock_i = 0, reset_i = 1, ext_reset_n_i = 1, wdt_timeout_i = 0, wdt_enable_i = 0;
	logic        sleep_wake_i = 0, wr_i = 0, rd_i = 0, wdt_osc_tick_i, core_reset_o, io_reset_o;
	logic        core_stall_o, wdt_reset_pulse_o;
	logic [1:0]  start_up_time_fuses_i = 2'h0;
	logic [5:0]  addr_i = 6'h00;
	logic [7:0]  wdata_i = 8'h00, rdata_o;
	logic [15:0] start_address_o;
	int          mismatches = 0, checks_done = 0, cyc = 0, n;
	int          nt [4] = '{0, OSC_CYCLES_01, OSC_CYCLES_10, OSC_CYCLES_11};

	rss_sequencer dut (.clock_i, .reset_i, .ext_reset_n_i, .wdt_timeout_i, .wdt_enable_i, .wdt_osc_tick_i,
		.start_up_time_fuses_i, .sleep_wake_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .core_reset_o,
		.io_reset_o, .core_stall_o, .wdt_reset_pulse_o, .start_address_o);
	rss_osc_model osc (.clock_i, .tick_o(wdt_osc_tick_i));

	// Clock and hang guard
	always #25 clock_i = ~clock_i;
	always @(posedge clock_i) if (++cyc == 60000) begin mismatches++; stop_test(); end

	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end
	endtask
	task automatic chk_rng(string nm, int lo, int hi, int g);
		checks_done++;
		if (g < lo || g > hi) begin mismatches++; $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g); end
	endtask
	task automatic wr(logic [5:0] a, logic [7:0] v);
		@(posedge clock_i) begin wr_i <= 1; addr_i <= a; wdata_i <= v; end
		@(posedge clock_i) wr_i <= 0;
	endtask
	task automatic rd_chk(string nm, logic [5:0] a, logic [7:0] e);
		@(posedge clock_i) begin rd_i <= 1; addr_i <= a; end
		@(posedge clock_i) rd_i <= 0;
		@(negedge clock_i) chk(nm, e, rdata_o);
	endtask
	// Cycles until the core leaves reset
	task automatic rel_wait();
		n = 0;
		do begin @(negedge clock_i); n++; end while (core_reset_o === 1'b1 && n < 40000);
	endtask
	task automatic wdt(logic en);
		@(posedge clock_i) begin wdt_enable_i <= en; wdt_timeout_i <= 1; end
		@(posedge clock_i) wdt_timeout_i <= 0;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		// Power-up with each start-up setting, ending on the fast one
		for (int f = 3; f >= 0; f--)
		begin
			@(posedge clock_i) begin reset_i <= 1; start_up_time_fuses_i <= 2'(f); end
			repeat (10) @(posedge clock_i);
			reset_i <= 0;
			rel_wait();
			chk_rng("release", f ? 2 * nt[f] - 2 : CLOCK_CYCLES_00 + 3, f ? 2 * nt[f] + 4 : CLOCK_CYCLES_00 + 3, n);
		end
		rd_chk("cause power", 6'h34, 8'h01);
		rd_chk("unmapped", 6'h35, 8'h00);
		wr(6'h34, 8'hff);
		rd_chk("cause set", 6'h34, 8'h03);
		wr(6'h34, 8'h00);
		$display("test power-up done");
		// Pin reset, then again within the delay
		@(posedge clock_i) ext_reset_n_i <= 0;
		#10 chk("core held", 8'(core_reset_o), 8'h01);
		repeat (2) @(posedge clock_i);
		ext_reset_n_i <= 1;
		repeat (3) @(posedge clock_i);
		ext_reset_n_i <= 0;
		repeat (2) @(posedge clock_i);
		ext_reset_n_i <= 1;
		rel_wait();
		chk_rng("pin restart", CLOCK_CYCLES_00 + 3, CLOCK_CYCLES_00 + 3, n);
		rd_chk("cause pin", 6'h34, 8'h02);
		$display("test pin done");
		// Watchdog off, then on twice
		wdt(0);
		repeat (3) @(negedge clock_i);
		chk("wdt off", 8'(core_reset_o), 8'h00);
		wdt(1);
		rel_wait();
		chk_rng("wdt release", CLOCK_CYCLES_00 + 3, CLOCK_CYCLES_00 + 3, n);
		rd_chk("cause kept", 6'h34, 8'h02);
		wr(6'h34, 8'h00);
		wdt(1);
		rel_wait();
		rd_chk("cause wdt", 6'h34, 8'h00);
		@(posedge clock_i) wdt_enable_i <= 0;
		$display("test watchdog done");
		// Wake from deep sleep
		@(posedge clock_i) sleep_wake_i <= 1;
		@(posedge clock_i) sleep_wake_i <= 0;
		@(negedge clock_i) chk("stall", 8'(core_stall_o), 8'h01);
		repeat (CLOCK_CYCLES_00 - 1) @(negedge clock_i);
		chk("stall held", 8'(core_stall_o), 8'h01);
		@(negedge clock_i);
		chk("stall end", 8'(core_stall_o), 8'h00);
		$display("test wake done");
		// Pin held low across power-up lengthens the reset
		@(posedge clock_i) begin reset_i <= 1; ext_reset_n_i <= 0; end
		repeat (10) @(posedge clock_i);
		reset_i <= 0;
		repeat (20) @(negedge clock_i);
		chk("pin extends", 8'(core_reset_o), 8'h01);
		@(posedge clock_i) ext_reset_n_i <= 1;
		rel_wait();
		chk_rng("extended release", CLOCK_CYCLES_00 + 3, CLOCK_CYCLES_00 + 3, n);
		rd_chk("cause both", 6'h34, 8'h03);
		$display("test extended power-up done");
		stop_test();
	end
endmodule // tb
